// file: cmd_regs_pkg.sv
// constants shared by the command and converter-control register bank
package cmd_regs_pkg;
    // serial frame layout
    localparam int unsigned FRAME_BITS      = 24;
    localparam int unsigned BITCNT_W        = 5;
    localparam int unsigned RW_BIT          = 23;
    localparam int unsigned DATA_MSB        = 15;
    // command selector in data bits 15..13
    localparam int unsigned SEL_MSB         = 15;
    localparam int unsigned SEL_LSB         = 13;
    localparam logic [2:0]  SEL_SW_CMD      = 3'h4;
    localparam logic [2:0]  SEL_BOOST_CTRL  = 3'h3;
    // software command fields
    localparam int unsigned TOGGLE_BIT      = 12;
    localparam int unsigned CODE_MSB        = 11;
    localparam logic [11:0] RESET_CODE      = 12'h555;
    localparam logic [11:0] KEEPALIVE_CODE  = 12'h195;
    // boost control field positions
    localparam int unsigned COMP_BIT        = 6;
    localparam int unsigned PHASE_LSB       = 4;
    localparam int unsigned FREQ_LSB        = 2;
    localparam int unsigned CEIL_LSB        = 0;
    // values after reset
    localparam logic        COMP_RESET      = 1'b0;
    localparam logic [1:0]  PHASE_RESET     = 2'h0;
    localparam logic [1:0]  FREQ_RESET      = 2'h1;
    localparam logic [1:0]  CEIL_RESET      = 2'h0;
    localparam logic        TOGGLE_RESET    = 1'b0;
    // switching frequency: divide of the internal oscillator, in kHz
    localparam int unsigned OSC_KHZ         = 13000;
    localparam int unsigned FSW0_KHZ        = 250;
    localparam int unsigned FSW1_KHZ        = 410;
    localparam int unsigned FSW2_KHZ        = 650;
    localparam logic [7:0]  DIV_250         = 8'((OSC_KHZ + FSW0_KHZ / 2) / FSW0_KHZ);
    localparam logic [7:0]  DIV_410         = 8'((OSC_KHZ + FSW1_KHZ / 2) / FSW1_KHZ);
    localparam logic [7:0]  DIV_650         = 8'((OSC_KHZ + FSW2_KHZ / 2) / FSW2_KHZ);
    // phase offsets per channel in quarter periods
    localparam logic [1:0]  PH_0            = 2'h0;
    localparam logic [1:0]  PH_90           = 2'h1;
    localparam logic [1:0]  PH_180          = 2'h2;
    localparam logic [1:0]  PH_270          = 2'h3;
    // watchdog counter
    localparam int unsigned WD_W            = 32;
    localparam logic [31:0] WD_RESET        = 32'h0000_0000;
endpackage

// file: serial_frame_rx.sv
// serial frame receiver: synchronises the link pins and delivers whole frames
`timescale 1ns/1ps
`default_nettype none
module serial_frame_rx
    import cmd_regs_pkg::*;
(
    input  wire logic                  sys_clk_i,
    input  wire logic                  rst_i,
    input  wire logic                  serial_clk_i,
    input  wire logic                  frame_sync_n_i,
    input  wire logic                  serial_data_in_i,
    output logic                       frame_valid_o,
    output logic [FRAME_BITS-1:0]      frame_word_o
);
    // ==========================================================
    // pin synchronisers
    logic [1:0]            sclk_meta_reg;    // [0] is read only by [1]
    logic [1:0]            sync_meta_reg;
    logic [1:0]            serial_data_in_meta_reg;
    logic                  sclk_prev_reg;    // for edge detection
    logic                  sync_prev_reg;
    logic [FRAME_BITS-1:0] shift_reg;        // incoming bits, msb first
    logic [BITCNT_W-1:0]   bitcnt_reg;       // saturating bit count

    // two flops per pin before any logic looks at it
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            sclk_meta_reg <= 2'h0;
            sync_meta_reg <= 2'h3;
            serial_data_in_meta_reg <= 2'h0;
            sclk_prev_reg <= 1'b0;
            sync_prev_reg <= 1'b1;
        end
        else
        begin
            sclk_meta_reg <= {sclk_meta_reg[0], serial_clk_i};
            sync_meta_reg <= {sync_meta_reg[0], frame_sync_n_i};
            serial_data_in_meta_reg <= {serial_data_in_meta_reg[0], serial_data_in_i};
            sclk_prev_reg <= sclk_meta_reg[1];
            sync_prev_reg <= sync_meta_reg[1];
        end
    end

    // ==========================================================
    // shifting on falling serial clock edges inside the frame
    logic fall_edge;
    logic frame_end;
    assign fall_edge = sclk_prev_reg & ~sclk_meta_reg[1] & ~sync_meta_reg[1];
    assign frame_end = ~sync_prev_reg & sync_meta_reg[1];

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            shift_reg  <= '0;
            bitcnt_reg <= '0;
        end
        else if (frame_end)
            bitcnt_reg <= '0;
        else if (fall_edge)
        begin
            shift_reg <= {shift_reg[FRAME_BITS-2:0], serial_data_in_meta_reg[1]};
            // saturate so an over-long frame is rejected, not wrapped
            if (bitcnt_reg != BITCNT_W'(FRAME_BITS + 1))
                bitcnt_reg <= bitcnt_reg + 1'b1;
        end
    end

    // only frames of exactly the nominal length are handed on
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            frame_valid_o <= 1'b0;
            frame_word_o  <= '0;
        end
        else
        begin
            frame_valid_o <= frame_end && (bitcnt_reg == BITCNT_W'(FRAME_BITS));
            if (frame_end)
                frame_word_o <= shift_reg;
        end
    end
endmodule
`default_nettype wire

// file: cmd_regs.sv
// software command and boost converter control register bank
// Operation
// RQ1 - data top bits 100 select software command
// RQ2 - command bit 12 copied to status bit 11
// RQ3 - reset code in low bits resets device
// RQ4 - host sends keep-alive before each timeout
// RQ5 - missed keep-alive raises fault alert
// RQ6 - keep-alive needed only with watchdog enabled
// RQ7 - data top bits 011 select converter control
// RQ8 - compensation bit defaults internal, 1 bypasses
// RQ9 - phase field sets channel clock edges
// RQ10 - frequency field picks oscillator divide ratio
// RQ11 - ceiling field picks boost voltage limit
// RQ12 - other codes only update toggle bit
// RQ13 - watchdog inputs external, keep-alive restarts count
`timescale 1ns/1ps
`default_nettype none
module cmd_regs
    import cmd_regs_pkg::*;
(
    input  wire logic             sys_clk_i,
    input  wire logic             rst_i,
    input  wire logic             serial_clk_i,
    input  wire logic             frame_sync_n_i,
    input  wire logic             serial_data_in_i,
    input  wire logic             wd_enable_i,
    input  wire logic [WD_W-1:0]  wd_timeout_i,
    output logic                  soft_reset_o,
    output logic                  keepalive_o,
    output logic                  fault_alert_o,
    output logic                  status_toggle_o,
    output logic                  comp_resistor_select_o,
    output logic [1:0]            converter_phase_field_o,
    output logic [1:0]            switching_freq_field_o,
    output logic [1:0]            boost_ceiling_field_o,
    output logic [7:0]            switching_div_o,
    output logic [7:0]            channel_phase_o,
    output logic [15:0]           boost_ctrl_readback_o
);
    // ==========================================================
    // frame reception
    logic                  frame_valid;   // one-cycle pulse per good frame
    logic [FRAME_BITS-1:0] frame_word;

    serial_frame_rx u_rx (
        .sys_clk_i        (sys_clk_i),
        .rst_i            (rst_i),
        .serial_clk_i     (serial_clk_i),
        .frame_sync_n_i   (frame_sync_n_i),
        .serial_data_in_i (serial_data_in_i),
        .frame_valid_o    (frame_valid),
        .frame_word_o     (frame_word)
    );

    // ==========================================================
    // write decode
    logic        is_write;     // read requests never touch these registers
    logic [2:0]  sel;          // command selector bits
    logic        sw_wr;        // software command write
    logic        boost_wr;     // converter control write
    logic        reset_hit;    // reset code seen
    logic        keep_hit;     // keep-alive code seen

    assign is_write  = frame_valid & ~frame_word[RW_BIT];
    assign sel       = frame_word[SEL_MSB:SEL_LSB];
    assign sw_wr     = is_write && (sel == SEL_SW_CMD);              // RQ1
    assign boost_wr  = is_write && (sel == SEL_BOOST_CTRL);          // RQ7
    assign reset_hit = sw_wr && (frame_word[CODE_MSB:0] == RESET_CODE);     // RQ3
    assign keep_hit  = sw_wr && (frame_word[CODE_MSB:0] == KEEPALIVE_CODE); // RQ13

    // ==========================================================
    // soft reset and keep-alive pulses
    // the registered pulse also returns this bank to defaults one cycle later
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            soft_reset_o <= 1'b0;
            keepalive_o  <= 1'b0;
        end
        else
        begin
            soft_reset_o <= reset_hit;    // RQ3
            keepalive_o  <= keep_hit;     // RQ13
        end
    end

    logic bank_rst;   // hard or soft reset of the bank
    assign bank_rst = rst_i | soft_reset_o;

    // ==========================================================
    // user toggle mirror
    // a reset write also carries bit 12, but the reset that follows wins
    always_ff @(posedge sys_clk_i)
    begin
        if (bank_rst)
            status_toggle_o <= TOGGLE_RESET;
        else if (sw_wr)
            status_toggle_o <= frame_word[TOGGLE_BIT];   // RQ2 RQ12
    end

    // ==========================================================
    // converter control register; bits 12..7 are don't care
    always_ff @(posedge sys_clk_i)
    begin
        if (bank_rst)
        begin
            comp_resistor_select_o  <= COMP_RESET;     // RQ8
            converter_phase_field_o <= PHASE_RESET;
            switching_freq_field_o  <= FREQ_RESET;
            boost_ceiling_field_o   <= CEIL_RESET;     // RQ11
        end
        else if (boost_wr)
        begin
            comp_resistor_select_o  <= frame_word[COMP_BIT];                 // RQ8
            converter_phase_field_o <= frame_word[PHASE_LSB+1:PHASE_LSB];    // RQ9
            switching_freq_field_o  <= frame_word[FREQ_LSB+1:FREQ_LSB];      // RQ10
            boost_ceiling_field_o   <= frame_word[CEIL_LSB+1:CEIL_LSB];      // RQ11
        end
    end

    // readback image: selector bits, don't care bits as zero, then fields
    assign boost_ctrl_readback_o = {SEL_BOOST_CTRL, 6'h00, comp_resistor_select_o,
                                    converter_phase_field_o, switching_freq_field_o,
                                    boost_ceiling_field_o};

    // ==========================================================
    // derived converter settings, registered so data outputs come from flops
    logic [7:0] div_next;     // oscillator divide ratio
    logic [7:0] phase_next;   // {d, c, b, a} quarter-period offsets

    always_comb
    begin
        unique case (switching_freq_field_o)
            2'h0:    div_next = DIV_250;   // RQ10
            2'h2:    div_next = DIV_650;
            default: div_next = DIV_410;   // 01, and undefined 11 falls back
        endcase
    end

    always_comb
    begin
        unique case (converter_phase_field_o)
            2'h0: phase_next = {PH_0,   PH_0,   PH_0,  PH_0};   // RQ9
            2'h1: phase_next = {PH_180, PH_180, PH_0,  PH_0};
            2'h2: phase_next = {PH_180, PH_0,   PH_180, PH_0};
            2'h3: phase_next = {PH_270, PH_180, PH_90, PH_0};
        endcase
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            switching_div_o <= DIV_410;
            channel_phase_o <= {PH_0, PH_0, PH_0, PH_0};
        end
        else
        begin
            switching_div_o <= div_next;
            channel_phase_o <= phase_next;
        end
    end

    // ==========================================================
    // watchdog: counts while enabled, cleared by keep-alive
    // the host owes keep-alives only while enabled (RQ4, RQ6)
    logic [WD_W-1:0] wd_count_reg;
    logic            wd_expire;
    assign wd_expire = wd_enable_i && !keep_hit && (wd_count_reg + 1'b1 >= wd_timeout_i);

    always_ff @(posedge sys_clk_i)
    begin
        if (bank_rst || !wd_enable_i || keep_hit)
            wd_count_reg <= WD_RESET;                     // RQ13
        else if (!wd_expire)
            wd_count_reg <= wd_count_reg + 1'b1;
    end

    // alert holds until a keep-alive, disable or reset
    always_ff @(posedge sys_clk_i)
    begin
        if (bank_rst || !wd_enable_i || keep_hit)
            fault_alert_o <= 1'b0;
        else if (wd_expire)
            fault_alert_o <= 1'b1;                        // RQ5
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    // a frame that is a read or carries another selector must leave the mirror alone
    sel_sw_cmd_a: assert property (frame_valid && (frame_word[23] || sel != 3'h4) // RQ1
            && !soft_reset_o |=> $stable(status_toggle_o))
        else $error("toggle written without a 100 selector write");
    toggle_copy_a: assert property (sw_wr && !reset_hit // RQ2
            |=> status_toggle_o == $past(frame_word[12]))
        else $error("toggle bit not mirrored");
    soft_reset_a: assert property (reset_hit |=> soft_reset_o // RQ3
            ##1 (switching_freq_field_o == 2'h1 && !status_toggle_o))
        else $error("reset code did not restore defaults");
    wd_alert_a: assert property (wd_enable_i && wd_timeout_i == 32'h4 && !bank_rst && !keep_hit // RQ5
            ##1 (wd_enable_i && !keep_hit && !bank_rst && wd_timeout_i == 32'h4)[*4]
            |=> fault_alert_o)
        else $error("watchdog expiry did not raise alert");
    wd_restart_a: assert property (keep_hit && !soft_reset_o // RQ13
            |=> wd_count_reg == 32'h0 && !fault_alert_o)
        else $error("keep-alive did not restart watchdog");
    boost_fields_a: assert property (boost_wr && !soft_reset_o // RQ7
            |=> boost_ctrl_readback_o[6:0] == $past(frame_word[6:0]))
        else $error("converter control fields not stored");
    comp_stable_a: assert property (!boost_wr && !soft_reset_o // RQ8
            |=> $stable(comp_resistor_select_o))
        else $error("compensation select changed without write");
    phase_quad_a: assert property (converter_phase_field_o == 2'h3 |=> channel_phase_o == 8'he4) // RQ9
        else $error("quadrature phase map wrong");
    freq_div_a: assert property (switching_freq_field_o == 2'h0 |=> switching_div_o == 8'h34) // RQ10
        else $error("250 kHz divide wrong");
    other_code_a: assert property (sw_wr && !reset_hit && !keep_hit // RQ12
            |=> !soft_reset_o && !keepalive_o)
        else $error("other code caused an action");

    soft_reset_c: cover property (reset_hit ##2 !soft_reset_o);
    keepalive_c:  cover property (keep_hit);
    alert_c:      cover property ($rose(fault_alert_o));
    boost_wr_c:   cover property (boost_wr && frame_word[5:4] == 2'h3);
endmodule
`default_nettype wire

// file: host_link_model.sv
// host side of the serial link: drives write and read frames into the register bank
`timescale 1ns/1ps
`default_nettype none
module host_link_model
    import cmd_regs_pkg::*;
(
    input  wire logic sys_clk_i,
    output logic      serial_clk_o,
    output logic      frame_sync_n_o,
    output logic      serial_data_o
);
    // ==========================================
    // link timing
    // half period in system cycles; 8 x 8 ns is the nearest whole-cycle fit to 62.5 ns
    localparam int HALF = 8;
    // idle: link clock stands high, frame select high
    initial
    begin
        serial_clk_o   = 1'b1;
        frame_sync_n_o = 1'b1;
        serial_data_o  = 1'b0;
    end
    // ==========================================
    // frames
    // one frame, msb first; caller puts the selector in data bits 15..13
    task automatic send(input logic [23:0] word);
        frame_sync_n_o <= 1'b0;
        repeat (HALF) @(posedge sys_clk_i);
        for (int i = 23; i >= 0; i--)
        begin
            serial_data_o <= word[i];
            serial_clk_o  <= 1'b1;
            repeat (HALF) @(posedge sys_clk_i);
            // bit is taken on this fall
            serial_clk_o <= 1'b0;
            repeat (HALF) @(posedge sys_clk_i);
        end
        serial_clk_o <= 1'b1;
        repeat (HALF) @(posedge sys_clk_i);
        frame_sync_n_o <= 1'b1;
        // released line shows the inverse so a stale bit cannot pass for data
        serial_data_o <= ~word[0];
        repeat (HALF) @(posedge sys_clk_i);
    endtask
    // keep-alive write; sent only while the watchdog is on
    task automatic keepalive();
        send({8'h00, SEL_SW_CMD, 1'b0, KEEPALIVE_CODE});
    endtask
endmodule
`default_nettype wire

// file: cmd_regs_test.sv
// self-checking testbench for the command and converter-control register bank
`timescale 1ns/1ps
`default_nettype none
module cmd_regs_test
    import cmd_regs_pkg::*;
;
    // ==========================================
    // signals
    logic            sys_clk, rst, sclk, sync_n, serial_data_in, wd_en;
    logic [WD_W-1:0] wd_to;
    logic            sr, ka, alert, tog, comp;
    logic [1:0]      ph, fq, ceil;
    logic [7:0]      div, chph;
    logic [15:0]     rb;
    int              checks, miscompares, sr_cnt, ka_cnt;
    // ==========================================
    // clock and instances
    initial
    begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    host_link_model i_host (.sys_clk_i(sys_clk), .serial_clk_o(sclk),
        .frame_sync_n_o(sync_n), .serial_data_o(serial_data_in));
    cmd_regs i_dut (.sys_clk_i(sys_clk), .rst_i(rst), .serial_clk_i(sclk),
        .frame_sync_n_i(sync_n), .serial_data_in_i(serial_data_in), .wd_enable_i(wd_en),
        .wd_timeout_i(wd_to), .soft_reset_o(sr), .keepalive_o(ka), .fault_alert_o(alert),
        .status_toggle_o(tog), .comp_resistor_select_o(comp), .converter_phase_field_o(ph),
        .switching_freq_field_o(fq), .boost_ceiling_field_o(ceil), .switching_div_o(div),
        .channel_phase_o(chph), .boost_ctrl_readback_o(rb));
    // pulse counters: one-cycle pulses are seen in their own cycle
    always @(posedge sys_clk)
    begin
        if (sr === 1'b1) sr_cnt++;
        if (ka === 1'b1) ka_cnt++;
    end
    // ==========================================
    // helpers
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // expected divide ratio; unused code 11 falls back to 32
    function automatic logic [7:0] exp_div(input logic [1:0] c);
        return (c == 2'h0) ? DIV_250 : (c == 2'h2) ? DIV_650 : DIV_410;
    endfunction
    // expected {D,C,B,A} quarter-period offsets
    function automatic logic [7:0] exp_ph(input logic [1:0] c);
        case (c)
            2'h1:    return {PH_180, PH_180, PH_0, PH_0};
            2'h2:    return {PH_180, PH_0, PH_180, PH_0};
            2'h3:    return {PH_270, PH_180, PH_90, PH_0};
            default: return 8'h00;
        endcase
    endfunction
    // compare every converter field against one code set
    task automatic check_boost(input logic c, input logic [1:0] p, f, v);
        repeat (12) @(posedge sys_clk);
        check("comp", comp, c);
        check("phase", ph, p);
        check("chph", chph, exp_ph(p));
        check("freq", fq, f);
        check("div", div, exp_div(f));
        check("ceil", ceil, v);
        check("rb", rb, {3'h3, 6'h00, c, p, f, v});
    endtask
    // ==========================================
    // scenarios
    task automatic t_boost();
        check_boost(COMP_RESET, PHASE_RESET, FREQ_RESET, CEIL_RESET);
        check("tog0", tog, TOGGLE_RESET);
        for (int i = 0; i < 4; i++)
        begin
            // junk in the ignored bits 12..7
            i_host.send({8'h00, SEL_BOOST_CTRL, 6'h2a, i[0], i[1:0], i[1:0], ~i[1:0]});
            check_boost(i[0], i[1:0], i[1:0], ~i[1:0]);
        end
    endtask
    task automatic t_toggle();
        int s0, k0;
        s0 = sr_cnt;
        k0 = ka_cnt;
        i_host.send({8'h00, SEL_SW_CMD, 1'b1, 12'h123});
        repeat (12) @(posedge sys_clk);
        check("tog1", tog, 1'b1);
        check("srpulse", sr_cnt - s0, 0);
        check("kapulse", ka_cnt - k0, 0);
        // wrong selector with bit 12 low, then a read frame: both ignored
        i_host.send({8'h00, 3'h0, 13'h0fff});
        i_host.send({8'h80, SEL_BOOST_CTRL, 13'h0000});
        check_boost(1'b1, 2'h3, 2'h3, 2'h0);
        check("tog_keep", tog, 1'b1);
        i_host.send({8'h00, SEL_SW_CMD, 1'b0, 12'h123});
        repeat (12) @(posedge sys_clk);
        check("tog0b", tog, 1'b0);
    endtask
    task automatic t_reset();
        int s0;
        s0 = sr_cnt;
        i_host.send({8'h00, SEL_SW_CMD, 1'b1, 12'h000});
        i_host.send({8'h00, SEL_SW_CMD, 1'b1, RESET_CODE});
        repeat (12) @(posedge sys_clk);
        check("srcnt", sr_cnt - s0, 1);
        check("togr", tog, 1'b0);
        check_boost(COMP_RESET, PHASE_RESET, FREQ_RESET, CEIL_RESET);
    endtask
    task automatic t_watchdog();
        int k0, n;
        wd_to <= 32'h0000_07d0;
        repeat (2100) @(posedge sys_clk);
        check("alert_off", alert, 1'b0);
        wd_en <= 1'b1;
        k0 = ka_cnt;
        for (int i = 0; i < 4; i++) i_host.keepalive();
        check("kacnt", ka_cnt - k0, 4);
        check("alert_fed", alert, 1'b0);
        n = 0;
        while (alert !== 1'b1 && n < 2200)
        begin
            @(posedge sys_clk);
            n++;
        end
        if (n >= 2200)
        begin
            // a watchdog that never fires is a failure, not a hang
            miscompares++;
            end_of_test();
        end
        // the last keep-alive landed a few cycles before the task returned
        check("alert_time", (n >= 1985 && n <= 2000), 1'b1);
        @(posedge sys_clk);
        wd_en <= 1'b0;
        repeat (4) @(posedge sys_clk);
        check("alert_clr", alert, 1'b0);
        // short timeout with no keep-alive: alert after four counted cycles
        wd_to <= 32'h0000_0004;
        wd_en <= 1'b1;
        repeat (2) @(posedge sys_clk);
        check("alert_early", alert, 1'b0);
        repeat (4) @(posedge sys_clk);
        check("alert_short", alert, 1'b1);
        @(posedge sys_clk);
        wd_en <= 1'b0;
        repeat (4) @(posedge sys_clk);
        check("alert_clr2", alert, 1'b0);
    endtask
    // ==========================================
    // main sequence
    initial
    begin
        rst = 1'b1;
        wd_en = 1'b0;
        wd_to = 32'h0000_0000;
        checks = 0;
        miscompares = 0;
        sr_cnt = 0;
        ka_cnt = 0;
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (8) @(posedge sys_clk);
        t_boost();
        t_toggle();
        t_reset();
        t_watchdog();
        end_of_test();
    end
endmodule
`default_nettype wire
